// File: src/psrc_top.sv
// Strap sampling, reset sequencing, sleep and power-down control with
// indicator pin drivers. Assumes a register master on a strobe port.
// Functional notes
// - Hardware reset pin or software reset bit puts the device in reset.
// - Internal reset continues for an extended time after hardware reset release.
// - Pause strap high advertises pause during auto-negotiation, low does not.
// - Sleep pin high permits sleep mode entry.
// - In managed mode the sleep-enable bit overrides the sleep pin.
// - Power-down pin high holds the device powered down until it falls.
// - Each of three indicator pins shows a condition selected by configuration.
// - Indicator pins are sampled as straps during reset, then driven.
// - With management on, straps only set defaults; software owns bits afterwards.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module psrc_top #(
	parameter int EXT_RESET_CYCLES = psrc_pkg::EXT_RESET_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic PAUSE_PIN,
	input wire logic SLEEP_PIN,
	input wire logic POWER_DOWN_PIN,
	input wire logic MGMT_ACCESS_DISABLE,
	input wire logic LINK_UP,
	input wire logic ACTIVITY,
	input wire logic FULL_DUPLEX,
	input wire logic SPEED_100,
	input wire logic LINE_IDLE,
	input wire logic [2:0] INDICATOR_CFG_PIN_IN,
	output logic [2:0] INDICATOR_CFG_PIN_OUT,
	output logic [2:0] INDICATOR_CFG_PIN_OE,
	output logic CORE_RESET,
	output logic ADV_PAUSE,
	output logic SLEEP_MODE,
	output logic POWER_DOWN,
	output logic [2:0] CFG_STRAPS
);
	// Elaboration check: the sequencer needs at least one reset cycle
	if (EXT_RESET_CYCLES < 1) begin : g_bad_reset_count
		$error("EXT_RESET_CYCLES must be at least 1");
	end

	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_RUN = 3'b100
	} psrc_state_t;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [6:0] pin_lvl;
	psrc_sync #(.WIDTH(7)) u_sync (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.ce(CE),
		.pin({INDICATOR_CFG_PIN_IN, MGMT_ACCESS_DISABLE, POWER_DOWN_PIN,
			SLEEP_PIN, PAUSE_PIN}),
		.level(pin_lvl)
	);
	logic pause_lvl;
	logic sleep_lvl;
	logic pdown_lvl;
	logic mdis_lvl;
	logic [2:0] ind_lvl;
	assign pause_lvl = pin_lvl[0];
	assign sleep_lvl = pin_lvl[1];
	assign pdown_lvl = pin_lvl[2];
	assign mdis_lvl = pin_lvl[3];
	assign ind_lvl = pin_lvl[6:4];

	psrc_state_t state_reg;
	logic [31:0] cnt_reg;
	logic sw_reset_reg;
	logic sleep_en_reg;
	logic pause_en_reg;
	logic [15:0] ind_sel_reg;
	logic mgmt_reg;
	logic [2:0] strap_reg;
	logic [psrc_pkg::BLINK_BITS-1:0] blink_reg;
	logic reg_wr;
	assign reg_wr = WR && mgmt_reg && (state_reg == ST_RUN);

	// ---------------------------------------------------------------
	// Reset sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_RESET;
			cnt_reg <= 32'h0;
		end else if (CE) begin
			unique case (state_reg)
				ST_RESET: begin
					if (cnt_reg >= 32'(EXT_RESET_CYCLES - 1)) begin
						state_reg <= ST_SAMPLE;
						cnt_reg <= 32'h0;
					end else begin
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_SAMPLE: begin
					if (cnt_reg >= 32'(psrc_pkg::SAMPLE_CYCLES - 1)) begin
						state_reg <= ST_RUN;
						cnt_reg <= 32'h0;
					end else begin
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				ST_RUN: begin
					if (sw_reset_reg) begin
						state_reg <= ST_RESET;
						cnt_reg <= 32'h0;
					end
				end
				default: begin
					state_reg <= ST_RESET;
					cnt_reg <= 32'h0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Strap capture at the end of the sample window
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			strap_reg <= 3'h0;
			mgmt_reg <= 1'b0;
		end else if (CE && state_reg == ST_SAMPLE
			&& cnt_reg == 32'(psrc_pkg::SAMPLE_CYCLES - 1)) begin
			strap_reg <= ind_lvl;
			mgmt_reg <= !mdis_lvl;
		end
	end

	// ---------------------------------------------------------------
	// Control bits: pins give the sleep and pause defaults; with management on, software owns them afterwards, otherwise the pins keep control
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sw_reset_reg <= 1'b0;
			sleep_en_reg <= 1'b0;
			pause_en_reg <= 1'b0;
			ind_sel_reg <= psrc_pkg::IND_SEL_RESET;
		end else if (CE) begin
			if (state_reg != ST_RUN) begin
				// defaults follow pin levels during reset
				sw_reset_reg <= 1'b0;
				sleep_en_reg <= sleep_lvl;
				pause_en_reg <= pause_lvl;
				ind_sel_reg <= psrc_pkg::IND_SEL_RESET;
			end else if (reg_wr) begin
				if (ADDR == psrc_pkg::CFG_ADDR) begin
					sleep_en_reg <= WDATA[psrc_pkg::CFG_SLEEP_EN_BIT];
					pause_en_reg <= WDATA[psrc_pkg::CFG_PAUSE_BIT];
				end
				if (ADDR == psrc_pkg::CTRL_ADDR) begin
					sw_reset_reg <= WDATA[psrc_pkg::CTRL_SW_RESET_BIT];
				end
				if (ADDR == psrc_pkg::IND_ADDR) begin
					ind_sel_reg <= WDATA;
				end
			end else if (!mgmt_reg) begin
				// Without management, pins keep control
				sleep_en_reg <= sleep_lvl;
				pause_en_reg <= pause_lvl;
			end
		end
	end

	// ---------------------------------------------------------------
	// Power outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			CORE_RESET <= 1'b1;
			ADV_PAUSE <= 1'b0;
			SLEEP_MODE <= 1'b0;
			POWER_DOWN <= 1'b0;
			CFG_STRAPS <= 3'h0;
		end else if (CE) begin
			CORE_RESET <= (state_reg != ST_RUN) || sw_reset_reg;
			ADV_PAUSE <= pause_en_reg;
			// sleep allowed only when enabled and line idle
			SLEEP_MODE <= sleep_en_reg && LINE_IDLE && (state_reg == ST_RUN) && !pdown_lvl;
			POWER_DOWN <= pdown_lvl;
			CFG_STRAPS <= strap_reg;
		end
	end

	// ---------------------------------------------------------------
	// Indicator drivers; pins float while straps are being read
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			blink_reg <= '0;
		end else if (CE) begin
			blink_reg <= blink_reg + 1'b1;
		end
	end

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_ind
			logic on;
			always_comb begin
				unique case (ind_sel_reg[4*k+3 -: 4])
					4'h0: on = SPEED_100;
					4'h1: on = LINK_UP;
					4'h2: on = ACTIVITY;
					4'h3: on = FULL_DUPLEX;
					4'h4: on = LINK_UP || ACTIVITY;
					4'h5: on = blink_reg[psrc_pkg::BLINK_BITS-1];
					4'h6: on = 1'b1;
					default: on = 1'b0;
				endcase
			end
			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B) begin
					INDICATOR_CFG_PIN_OUT[k] <= 1'b0;
					INDICATOR_CFG_PIN_OE[k] <= 1'b0;
				end else if (CE) begin
					INDICATOR_CFG_PIN_OE[k] <= (state_reg == ST_RUN);
					// LED active low when its strap is high, polarity set by strap so the pull stays idle
					INDICATOR_CFG_PIN_OUT[k] <= on ^ strap_reg[k];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Register read port
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 16'h0;
		end else if (CE) begin
			RDATA <= 16'h0;
			if (RD && mgmt_reg) begin
				unique case (ADDR)
					psrc_pkg::CTRL_ADDR: RDATA[psrc_pkg::CTRL_SW_RESET_BIT] <= sw_reset_reg;
					psrc_pkg::CFG_ADDR: begin
						RDATA[psrc_pkg::CFG_SLEEP_EN_BIT] <= sleep_en_reg;
						RDATA[psrc_pkg::CFG_PAUSE_BIT] <= pause_en_reg;
					end
					psrc_pkg::IND_ADDR: RDATA <= ind_sel_reg;
					psrc_pkg::STAT_ADDR: begin
						RDATA[psrc_pkg::STAT_RESET_BIT] <= CORE_RESET;
						RDATA[psrc_pkg::STAT_PDOWN_BIT] <= POWER_DOWN;
						RDATA[psrc_pkg::STAT_SLEEP_BIT] <= SLEEP_MODE;
						RDATA[psrc_pkg::STAT_MGMT_BIT] <= mgmt_reg;
						RDATA[psrc_pkg::STAT_STRAP_LSB +: 3] <= strap_reg;
					end
					default: RDATA <= 16'h0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_sw_reset_core: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && sw_reset_reg |=> CORE_RESET)
		else $error("software reset did not reset core");
	a_ext_reset_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		state_reg == ST_RESET |-> CORE_RESET || $past(state_reg) != ST_RESET)
		else $error("core left reset early");
	a_pause_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && $past(CE) |-> ADV_PAUSE == $past(pause_en_reg))
		else $error("pause advert mismatch");
	a_sleep_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		SLEEP_MODE |-> $past(sleep_en_reg))
		else $error("sleep without enable");
	a_sleep_override: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && reg_wr && ADDR == psrc_pkg::CFG_ADDR |=>
		sleep_en_reg == $past(WDATA[psrc_pkg::CFG_SLEEP_EN_BIT]))
		else $error("sleep override not taken");
	a_pdown_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && pdown_lvl |=> POWER_DOWN && !SLEEP_MODE)
		else $error("power-down not held");
	a_strap_float: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		state_reg != ST_RUN && $past(state_reg) != ST_RUN |-> INDICATOR_CFG_PIN_OE == 3'h0)
		else $error("indicator driven during sampling");
	a_mgmt_lock: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && !mgmt_reg && state_reg == ST_RUN |=> sleep_en_reg == $past(sleep_lvl))
		else $error("pin control lost without management");
	a_ind_on: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CE && state_reg == ST_RUN && ind_sel_reg[3:0] == 4'h6 |=>
		INDICATOR_CFG_PIN_OUT[0] == !$past(strap_reg[0]))
		else $error("indicator select ignored");
endmodule // psrc_top

// File: shared/psrc_pkg.sv
// Constants for the strap, reset and power control block.
// Assumes a 200 MHz core clock; register map is reached over a plain strobe port.
package psrc_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] CTRL_ADDR = 5'h00;
	localparam logic [4:0] STAT_ADDR = 5'h01;
	localparam logic [4:0] CFG_ADDR = 5'h10;
	localparam logic [4:0] IND_ADDR = 5'h14;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_SW_RESET_BIT = 15;
	localparam int CFG_SLEEP_EN_BIT = 6;
	localparam int CFG_PAUSE_BIT = 10;
	localparam int STAT_RESET_BIT = 0;
	localparam int STAT_PDOWN_BIT = 1;
	localparam int STAT_SLEEP_BIT = 2;
	localparam int STAT_MGMT_BIT = 3;
	localparam int STAT_STRAP_LSB = 4;
	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [15:0] IND_SEL_RESET = 16'h0421;
	localparam int CLK_MHZ = 200;
	localparam int EXT_RESET_US = 300;
	localparam int EXT_RESET_CYCLES = EXT_RESET_US * CLK_MHZ;
	localparam int SAMPLE_CYCLES = 4;
	localparam int BLINK_BITS = 24;
endpackage

// File: src/psrc_sync.sv
// Three-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to CORE_CLK.
`timescale 1ns/1ps
module psrc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// Elaboration check: an empty pin group has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least 1");
	end

	// ---------------------------------------------------------------
	// Per-bit stages; a change counts once stages two and three agree
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
					level[i] <= 1'b0;
				end else if (ce) begin
					s1_reg[i] <= pin[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					if (s2_reg[i] == s3_reg[i]) begin
						level[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate
endmodule // psrc_sync

// File: tb/psrc_board.sv
// Board-side model of the three indicator/strap pins.
// Assumes a strap resistor on each pin and an indicator that follows the driven level.
`timescale 1ns/1ps
module psrc_board (
	input wire logic [2:0] strap,
	input wire logic [2:0] oe,
	input wire logic [2:0] drive,
	output logic [2:0] pin
);
	// strap then drive
	// Released pin falls back to its resistor level, so reset sees the strap
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin[i] = oe[i] ? drive[i] : strap[i];
		end
	end
endmodule // psrc_board

// File: tb/tb_top.sv
// Self-checking bench for the strap, reset and power control block.
// Assumes the board model on the indicator pins and a shortened reset count.
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// Stimulus and wiring
	// ----------------------------------------------------------------
	logic CORE_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic CE = 1'b1;
	logic [4:0] ADDR = 5'h00;
	logic [15:0] WDATA = 16'h0000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic PAUSE_PIN = 1'b1;
	logic SLEEP_PIN = 1'b0;
	logic POWER_DOWN_PIN = 1'b0;
	logic MGMT_ACCESS_DISABLE = 1'b0;
	logic [3:0] stat = 4'h0; // Speed, duplex, activity, link
	logic line_idle = 1'b1;
	logic [2:0] strap = 3'h0;
	logic [15:0] RDATA;
	logic [2:0] ind_in, ind_out, ind_oe, CFG_STRAPS;
	logic CORE_RESET, ADV_PAUSE, SLEEP_MODE, POWER_DOWN;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Short reset count keeps the run brief
	psrc_top #(.EXT_RESET_CYCLES(8)) dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CE(CE),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.PAUSE_PIN(PAUSE_PIN), .SLEEP_PIN(SLEEP_PIN), .POWER_DOWN_PIN(POWER_DOWN_PIN),
		.MGMT_ACCESS_DISABLE(MGMT_ACCESS_DISABLE), .LINK_UP(stat[0]), .ACTIVITY(stat[1]),
		.FULL_DUPLEX(stat[2]), .SPEED_100(stat[3]), .LINE_IDLE(line_idle),
		.INDICATOR_CFG_PIN_IN(ind_in), .INDICATOR_CFG_PIN_OUT(ind_out),
		.INDICATOR_CFG_PIN_OE(ind_oe), .CORE_RESET(CORE_RESET), .ADV_PAUSE(ADV_PAUSE),
		.SLEEP_MODE(SLEEP_MODE), .POWER_DOWN(POWER_DOWN), .CFG_STRAPS(CFG_STRAPS));
	psrc_board board (.strap(strap), .oe(ind_oe), .drive(ind_out), .pin(ind_in));
	always #2.5 CORE_CLK = ~CORE_CLK;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("MISMATCH %0t timeout", $time);
			results();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e,
		input string msg);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA & m, e, msg);
	endtask
	task automatic wait_run();
		int n = 0;
		while (CORE_RESET !== 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(16'(CORE_RESET), 16'h0000, "core stuck in reset");
	endtask
	task automatic hw_reset(input logic [2:0] s, input logic md);
		@(posedge CORE_CLK);
		RST_B <= 1'b0;
		strap <= s;
		MGMT_ACCESS_DISABLE <= md;
		cyc(12);
		chk(16'(CORE_RESET), 16'h0001, "pin reset ignored");
		chk(16'(ind_oe), 16'h0000, "pins driven in reset");
		RST_B <= 1'b1;
		cyc(8);
		chk(16'(CORE_RESET), 16'h0001, "reset cycle too short");
		wait_run();
	endtask
	function automatic logic ind_on(input int c, input logic [3:0] s);
		case (c)
			0: return s[3];
			1: return s[0];
			2: return s[1];
			3: return s[2];
			// Blink phase is still low this early after the pin reset
			5: return 1'b0;
			default: return s[0] | s[1];
		endcase
	endfunction
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		hw_reset(3'h5, 1'b0);
		chk(16'(CFG_STRAPS), 16'h0005, "strap latch");
		chk(16'(ind_oe), 16'h0007, "indicators not driven");
		rd(psrc_pkg::STAT_ADDR, 16'h007f, 16'h0058, "status");
		rd(psrc_pkg::IND_ADDR, 16'hffff, 16'h0421, "indicator reset");
		rd(5'h1f, 16'hffff, 16'h0000, "unmapped read");
		chk(16'(ADV_PAUSE), 16'h0001, "pause strap");
		$display("test straps done");
		wr(psrc_pkg::CFG_ADDR, 16'h0040);
		cyc(3);
		chk(16'(SLEEP_MODE), 16'h0001, "sleep bit");
		line_idle <= 1'b0;
		cyc(3);
		chk(16'(SLEEP_MODE), 16'h0000, "sleep on busy line");
		line_idle <= 1'b1;
		chk(16'(ADV_PAUSE), 16'h0000, "pause bit");
		rd(psrc_pkg::CFG_ADDR, 16'h0440, 16'h0040, "config readback");
		SLEEP_PIN <= 1'b1;
		wr(psrc_pkg::CFG_ADDR, 16'h0000);
		cyc(8);
		chk(16'(SLEEP_MODE), 16'h0000, "sleep pin override");
		$display("test managed done");
		// Pin 0 forced on, pin 1 off, pin 2 walks every status code and blink
		for (int p = 0; p < 2; p++) begin
			stat <= p ? 4'ha : 4'h5;
			for (int c = 0; c < 6; c++) begin
				wr(psrc_pkg::IND_ADDR, {4'h0, 4'(c), 4'h7, 4'h6});
				cyc(3);
				chk(16'(ind_out), 16'({ind_on(c, stat) ^ 1'b1, 2'b00}), "indicator");
			end
		end
		$display("test indicators done");
		wr(psrc_pkg::CTRL_ADDR, 16'h8000);
		cyc(3);
		chk(16'(CORE_RESET), 16'h0001, "software reset");
		// Clock enable low must freeze the reset count
		CE <= 1'b0;
		cyc(20);
		chk(16'(CORE_RESET), 16'h0001, "clock enable freeze");
		CE <= 1'b1;
		wait_run();
		rd(psrc_pkg::CTRL_ADDR, 16'h8000, 16'h0000, "reset bit stuck");
		chk(16'(ADV_PAUSE), 16'h0001, "default not restored");
		$display("test software reset done");
		PAUSE_PIN <= 1'b0;
		hw_reset(3'h2, 1'b1);
		chk(16'(CFG_STRAPS), 16'h0002, "strap latch");
		chk(16'(ADV_PAUSE), 16'h0000, "pause low");
		chk(16'(SLEEP_MODE), 16'h0001, "sleep pin");
		PAUSE_PIN <= 1'b1;
		SLEEP_PIN <= 1'b0;
		cyc(8);
		chk(16'(ADV_PAUSE), 16'h0001, "pause pin");
		chk(16'(SLEEP_MODE), 16'h0000, "sleep pin low");
		wr(psrc_pkg::CFG_ADDR, 16'h0040);
		cyc(3);
		chk(16'(SLEEP_MODE), 16'h0000, "write not refused");
		rd(psrc_pkg::CFG_ADDR, 16'hffff, 16'h0000, "refused read");
		POWER_DOWN_PIN <= 1'b1;
		SLEEP_PIN <= 1'b1;
		cyc(8);
		chk(16'(POWER_DOWN), 16'h0001, "power down");
		chk(16'(SLEEP_MODE), 16'h0000, "sleep while down");
		POWER_DOWN_PIN <= 1'b0;
		cyc(8);
		chk(16'(POWER_DOWN), 16'h0000, "power down stuck");
		chk(16'(SLEEP_MODE), 16'h0001, "sleep after power-up");
		$display("test unmanaged done");
		results();
	end
endmodule // tb_top
